// ### dfc_flash_model.sv
// behavioural flash array behind the controller
`timescale 1ns/1ps
module dfc_flash_model #(parameter int BUSY_CYCLES = 12) (
	// read port
	input  wire logic         clk_i,
	input  wire logic         rd_i,
	input  wire logic [14:0]  addr_i,
	output logic      [127:0] rdata_o,
	// program and erase port
	input  wire logic         start_i,
	input  wire logic [4:0]   op_i,
	input  wire logic [14:0]  waddr_i,
	input  wire logic [31:0]  wdata_i,
	output logic              done_o
);
	logic [127:0] mem [2048];
	logic [127:0] last;
	int           busy;
	initial begin
		for (int i = 0; i < 2048; i++)
			mem[i] = {4{32'ha5c3_0000 | i}};
		last = '0;
		busy = 0;
		done_o = 1'b0;
	end
	// released bus shows inverse of last line
	assign rdata_o = rd_i ? mem[addr_i[14:4]] : ~last;
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rd_i)
			last <= mem[addr_i[14:4]];
		if (start_i)
			busy <= BUSY_CYCLES;
		else if (busy > 0)
			busy <= busy - 1;
		if (busy == 1) begin
			done_o <= 1'b1;
			mem[waddr_i[14:4]][waddr_i[3:2]*32 +: 32] <= op_i[0] ? wdata_i : 32'hffff_ffff;
		end
	end
endmodule // dfc_flash_model

// ### dfc_pkg.sv
// constants and types for the data flash controller register block
// Operation
// - registers at fixed base, 32-bit words
// - wait field 0 to 15, extra read cycles
// - wait code n gives n wait cycles
// - unlock needs three key words in order
// - lock bits released only after full key
// - access control resets to 0x8000_0000
// - sixteen 2 KB region guard bits
// - eight 512-byte release bits override guard
// - bit 20 sequence fault, write-1 clear
// - bit 18 guard fault, write-1 clear
// - bit 17 otp lock fault, write-1 clear
// - bit 16 lock fault, write-1 clear
// - bit 8 write done, write-1 clear
// - bit 9 crc done, irq when enabled
// - accum clear reloads crc, self-clearing
// - crc16 ccitt, polynomial 0x1021
// - crc result read-only, resets 0xFFFF
// - end address resets to 0x7FFF
// - background when idle, burst holds cpu
// - crc consumes 128-bit flash lines
package dfc_pkg;
	// ***********************************************
	// address map
	// ***********************************************
	localparam logic [31:0] DFC_BASE_ADDR     = 32'h4100_1000;
	localparam logic [11:0] DFC_OFF_CONFIG    = 12'h000;
	localparam logic [11:0] DFC_OFF_KEY       = 12'h004;
	localparam logic [11:0] DFC_OFF_PROT      = 12'h00c;
	localparam logic [11:0] DFC_OFF_CTRL      = 12'h014;
	localparam logic [11:0] DFC_OFF_STAT      = 12'h018;
	localparam logic [11:0] DFC_OFF_CRC_CTRL  = 12'h030;
	localparam logic [11:0] DFC_OFF_CRC_OUT   = 12'h034;
	localparam logic [11:0] DFC_OFF_CRC_START = 12'h038;
	localparam logic [11:0] DFC_OFF_CRC_END   = 12'h03c;
	// ***********************************************
	// reset values and keys
	// ***********************************************
	localparam logic [31:0] DFC_CTRL_RESET    = 32'h8000_0000;
	localparam logic [15:0] DFC_CRC_INIT      = 16'hffff;
	localparam logic [14:0] DFC_CRC_END_RESET = 15'h7fff;
	localparam logic [15:0] DFC_CRC_POLY      = 16'h1021;
	localparam logic [31:0] DFC_FIRST_UNLOCK_WORD  = 32'h0123_4567;
	localparam logic [31:0] DFC_SECOND_UNLOCK_WORD = 32'h1234_5678;
	localparam logic [31:0] DFC_THIRD_UNLOCK_WORD  = 32'h2345_6789;
	// ***********************************************
	// field positions
	// ***********************************************
	localparam int DFC_CTRL_LOCK_BIT     = 31;
	localparam int DFC_CTRL_OTP_LOCK_BIT = 30;
	localparam int DFC_STAT_WR_BUSY_BIT  = 0;
	localparam int DFC_STAT_CRC_BUSY_BIT = 1;
	localparam int DFC_STAT_WR_DONE_BIT  = 8;
	localparam int DFC_STAT_CRC_DONE_BIT = 9;
	localparam int DFC_STAT_LOCK_BIT     = 16;
	localparam int DFC_STAT_OTP_BIT      = 17;
	localparam int DFC_STAT_GUARD_BIT    = 18;
	localparam int DFC_STAT_SEQ_BIT      = 20;
	localparam int DFC_CRC_BG_BIT        = 0;
	localparam int DFC_CRC_BURST_BIT     = 1;
	localparam int DFC_CRC_IRQEN_BIT     = 8;
	localparam int DFC_CRC_CLEAR_BIT     = 16;
	localparam logic [14:0] DFC_RELEASE_BASE = 15'h7000;
	localparam logic [14:0] DFC_LINE_STEP    = 15'h0010;
	// ***********************************************
	// types
	// ***********************************************
	typedef enum logic [1:0] {DFC_KEY_NONE, DFC_KEY_ONE, DFC_KEY_TWO, DFC_KEY_OPEN} dfc_key_t;
	typedef enum logic [1:0] {DFC_RD_IDLE, DFC_RD_MEM, DFC_RD_CRC} dfc_rd_t;
endpackage

// ### dfc_properties.sv
// port-level assertions for the data flash controller
`timescale 1ns/1ps
module dfc_properties (
	// clock and reset
	input wire logic        CLK_SYS_I,
	input wire logic        RESET_N_I,
	// apb
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic        PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PSLVERR_O,
	// flash side
	input wire logic [14:0] MEM_ADDR_I,
	input wire logic        MEM_ACK_O,
	input wire logic        ARR_RD_O,
	input wire logic        ARR_START_O,
	input wire logic [4:0]  ARR_OP_O,
	input wire logic [14:0] ARR_WADDR_O,
	input wire logic        CPU_HOLD_O,
	input wire logic        CRC_DONE_REQ_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);
	logic        acc;
	logic [3:0]  wait_q;
	logic        irqen_q;
	logic [4:0]  run_cnt;
	assign acc = PSEL_I && PENABLE_I;
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			wait_q <= 4'h0;
			irqen_q <= 1'b0;
			run_cnt <= 5'h00;
		end else begin
			if (acc && PWRITE_I && PADDR_I == 32'h4100_1000)
				wait_q <= PWDATA_I[3:0];
			if (acc && PWRITE_I && PADDR_I == 32'h4100_1030)
				irqen_q <= PWDATA_I[8];
			if (!ARR_RD_O)
				run_cnt <= 5'h00;
			else
				run_cnt <= run_cnt + 5'h01;
		end
	end
	property p_unmapped; acc && (PADDR_I[31:12] != 20'h41001 || PADDR_I[11:6] != 6'h0)
		|-> PSLVERR_O; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_err_rd; acc && !PWRITE_I && PSLVERR_O |-> PRDATA_O == 32'h0; endproperty
	a_err_rd: assert property (p_err_rd) else $error("refused read not zero");
	property p_key_rd; acc && !PWRITE_I && PADDR_I == 32'h4100_1004 |-> PRDATA_O == 32'h0; endproperty
	a_key_rd: assert property (p_key_rd) else $error("key readable");
	property p_ack; MEM_ACK_O |=> !MEM_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("ack too long");
	property p_start; ARR_START_O |-> MEM_ACK_O && $onehot(ARR_OP_O)
		&& ARR_WADDR_O == $past(MEM_ADDR_I) ##1 !ARR_START_O; endproperty
	a_start: assert property (p_start) else $error("bad array start");
	property p_rd_wait; MEM_ACK_O && $past(ARR_RD_O) |-> run_cnt == {1'b0, wait_q} + 5'h01;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("wrong read wait");
	property p_hold; acc && PWRITE_I && PADDR_I == 32'h4100_1030 && PWDATA_I[1:0] == 2'h2
		|-> ##[1:2] CPU_HOLD_O; endproperty
	a_hold: assert property (p_hold) else $error("no cpu hold");
	property p_irq; CRC_DONE_REQ_O |-> irqen_q; endproperty
	a_irq: assert property (p_irq) else $error("irq while disabled");
endmodule // dfc_properties

bind dfc_top dfc_properties u_dfc_properties (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .MEM_ADDR_I(MEM_ADDR_I),
	.MEM_ACK_O(MEM_ACK_O), .ARR_RD_O(ARR_RD_O),
	.ARR_START_O(ARR_START_O), .ARR_OP_O(ARR_OP_O), .ARR_WADDR_O(ARR_WADDR_O),
	.CPU_HOLD_O(CPU_HOLD_O), .CRC_DONE_REQ_O(CRC_DONE_REQ_O));

// ### dfc_top.sv
// data flash controller: apb registers, unlock, protection, status, crc engine
`timescale 1ns/1ps
module dfc_top (
	// clock and reset
	input  wire logic         CLK_SYS_I,
	input  wire logic         RESET_N_I,
	// apb slave
	input  wire logic         PSEL_I,
	input  wire logic         PENABLE_I,
	input  wire logic         PWRITE_I,
	input  wire logic [31:0]  PADDR_I,
	input  wire logic [31:0]  PWDATA_I,
	output logic              PREADY_O,
	output logic [31:0]       PRDATA_O,
	output logic              PSLVERR_O,
	// flash memory accesses from the system bus
	input  wire logic         MEM_REQ_I,
	input  wire logic         MEM_WRITE_I,
	input  wire logic         MEM_OTP_I,
	input  wire logic [14:0]  MEM_ADDR_I,
	input  wire logic [31:0]  MEM_WDATA_I,
	output logic              MEM_ACK_O,
	output logic [127:0]      MEM_RDATA_O,
	// flash array
	output logic              ARR_RD_O,
	output logic [14:0]       ARR_ADDR_O,
	input  wire logic [127:0] ARR_RDATA_I,
	output logic              ARR_START_O,
	output logic [4:0]        ARR_OP_O,
	output logic [14:0]       ARR_WADDR_O,
	output logic [31:0]       ARR_WDATA_O,
	input  wire logic         ARR_DONE_I,
	// system side
	output logic              CPU_HOLD_O,
	output logic              CRC_DONE_REQ_O
);
	// ***********************************************
	// registers
	// ***********************************************
	logic [3:0]        wait_reg;
	logic [31:0]       prot_reg;
	logic [31:0]       ctrl_reg;
	dfc_pkg::dfc_key_t key_reg;
	logic              seq_fault_reg;
	logic              guard_fault_reg;
	logic              otp_fault_reg;
	logic              lock_fault_reg;
	logic              write_done_reg;
	logic              crc_done_reg;
	logic              write_busy_reg;
	logic              crc_busy_reg;
	logic              crc_bg_reg;
	logic              crc_burst_reg;
	logic              crc_irqen_reg;
	logic [15:0]       crc_reg;
	logic [14:0]       crc_first_reg;
	logic [14:0]       crc_last_reg;
	logic [14:0]       crc_ptr_reg;
	dfc_pkg::dfc_rd_t  rd_state_reg;
	logic [3:0]        rd_cnt_reg;
	logic              mem_ack_reg;
	logic [127:0]      mem_rdata_reg;
	logic              arr_start_reg;
	logic [4:0]        arr_op_reg;
	logic [14:0]       arr_waddr_reg;
	logic [31:0]       arr_wdata_reg;
	logic [15:0]       crc_next;

	// ***********************************************
	// apb decode
	// ***********************************************
	logic        in_range;
	logic [11:0] off;
	logic        mapped;
	logic        wr_stb;
	logic        rd_phase;

	assign in_range = (PADDR_I[31:12] == dfc_pkg::DFC_BASE_ADDR[31:12]);
	assign off      = PADDR_I[11:0];
	always_comb begin
		case (off)
			dfc_pkg::DFC_OFF_CONFIG, dfc_pkg::DFC_OFF_KEY, dfc_pkg::DFC_OFF_PROT,
			dfc_pkg::DFC_OFF_CTRL, dfc_pkg::DFC_OFF_STAT, dfc_pkg::DFC_OFF_CRC_CTRL,
			dfc_pkg::DFC_OFF_CRC_OUT, dfc_pkg::DFC_OFF_CRC_START,
			dfc_pkg::DFC_OFF_CRC_END: mapped = in_range;
			default: mapped = 1'b0;
		endcase
	end
	// zero-wait slave: every access completes in its first access cycle
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
	assign wr_stb    = PSEL_I & PENABLE_I & PWRITE_I & mapped;
	assign rd_phase  = PSEL_I & ~PENABLE_I & ~PWRITE_I;

	function automatic logic wr_to(input logic [11:0] o);
		wr_to = wr_stb & (off == o);
	endfunction

	// ***********************************************
	// flash access checks
	// ***********************************************
	logic       rd_idle;
	logic       wr_req;
	logic       rd_req;
	logic       guarded;
	logic       released;
	logic       f_lock;
	logic       f_otp;
	logic       f_guard;
	logic       f_seq;
	logic       wr_ok;
	logic [4:0] mode;
	logic [2:0] blk;

	assign rd_idle  = (rd_state_reg == dfc_pkg::DFC_RD_IDLE);
	assign wr_req   = MEM_REQ_I & MEM_WRITE_I & rd_idle & ~mem_ack_reg;
	assign rd_req   = MEM_REQ_I & ~MEM_WRITE_I & rd_idle & ~mem_ack_reg & ~write_busy_reg;
	assign mode     = ctrl_reg[4:0];
	assign guarded  = prot_reg[MEM_ADDR_I[14:11]];
	assign blk      = MEM_ADDR_I[11:9];
	assign released = (MEM_ADDR_I[14:12] == dfc_pkg::DFC_RELEASE_BASE[14:12])
		& prot_reg[24 + int'(blk)];
	assign f_lock   = wr_req & ctrl_reg[dfc_pkg::DFC_CTRL_LOCK_BIT];
	assign f_otp    = MEM_REQ_I & rd_idle & ~mem_ack_reg & MEM_OTP_I
		& ctrl_reg[dfc_pkg::DFC_CTRL_OTP_LOCK_BIT];
	assign f_guard  = wr_req & ~MEM_OTP_I & guarded & ~released;
	// a write with no mode, several modes, or while busy is out of sequence
	assign f_seq    = wr_req & (~$onehot(mode) | write_busy_reg);
	assign wr_ok    = wr_req & ~f_lock & ~f_otp & ~f_guard & ~f_seq;

	// ***********************************************
	// configuration, protection, unlock
	// ***********************************************
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			wait_reg <= 4'h0;
		end else if (wr_to(dfc_pkg::DFC_OFF_CONFIG)) begin
			wait_reg <= PWDATA_I[3:0];
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			prot_reg <= 32'h0000_0000;
		end else if (wr_to(dfc_pkg::DFC_OFF_PROT)) begin
			prot_reg <= {PWDATA_I[31:24], 8'h00, PWDATA_I[15:0]};
		end
	end

	// apb writes to registers other than the control register between key words do not break the sequence
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			key_reg <= dfc_pkg::DFC_KEY_NONE;
		end else if (wr_to(dfc_pkg::DFC_OFF_KEY)) begin
			case (key_reg)
				dfc_pkg::DFC_KEY_NONE: key_reg <= (PWDATA_I == dfc_pkg::DFC_FIRST_UNLOCK_WORD)
					? dfc_pkg::DFC_KEY_ONE : dfc_pkg::DFC_KEY_NONE;
				dfc_pkg::DFC_KEY_ONE: key_reg <= (PWDATA_I == dfc_pkg::DFC_SECOND_UNLOCK_WORD)
					? dfc_pkg::DFC_KEY_TWO : dfc_pkg::DFC_KEY_NONE;
				dfc_pkg::DFC_KEY_TWO: key_reg <= (PWDATA_I == dfc_pkg::DFC_THIRD_UNLOCK_WORD)
					? dfc_pkg::DFC_KEY_OPEN : dfc_pkg::DFC_KEY_NONE;
				default: key_reg <= dfc_pkg::DFC_KEY_NONE;
			endcase
		end else if (wr_to(dfc_pkg::DFC_OFF_CTRL)) begin
			key_reg <= dfc_pkg::DFC_KEY_NONE; // one release per key sequence
		end
	end

	// lock bits may always be set; cleared only with the key open
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			ctrl_reg <= dfc_pkg::DFC_CTRL_RESET;
		end else if (wr_to(dfc_pkg::DFC_OFF_CTRL)) begin
			ctrl_reg[29:0] <= PWDATA_I[29:0];
			if (key_reg == dfc_pkg::DFC_KEY_OPEN) begin
				ctrl_reg[31:30] <= PWDATA_I[31:30];
			end else begin
				ctrl_reg[31:30] <= ctrl_reg[31:30] | PWDATA_I[31:30];
			end
		end
	end

	// ***********************************************
	// status flags: hardware set wins over write-1 clear
	// ***********************************************
	logic stat_wr;
	assign stat_wr = wr_to(dfc_pkg::DFC_OFF_STAT);

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			seq_fault_reg   <= 1'b0;
			guard_fault_reg <= 1'b0;
			otp_fault_reg   <= 1'b0;
			lock_fault_reg  <= 1'b0;
		end else begin
			seq_fault_reg   <= f_seq
				| (seq_fault_reg & ~(stat_wr & PWDATA_I[dfc_pkg::DFC_STAT_SEQ_BIT]));
			guard_fault_reg <= f_guard
				| (guard_fault_reg & ~(stat_wr & PWDATA_I[dfc_pkg::DFC_STAT_GUARD_BIT]));
			otp_fault_reg   <= f_otp
				| (otp_fault_reg & ~(stat_wr & PWDATA_I[dfc_pkg::DFC_STAT_OTP_BIT]));
			lock_fault_reg  <= f_lock
				| (lock_fault_reg & ~(stat_wr & PWDATA_I[dfc_pkg::DFC_STAT_LOCK_BIT]));
		end
	end

	logic crc_finish;

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			write_done_reg <= 1'b0;
			crc_done_reg   <= 1'b0;
		end else begin
			write_done_reg <= (write_busy_reg & ARR_DONE_I)
				| (write_done_reg & ~wr_ok
				& ~(stat_wr & PWDATA_I[dfc_pkg::DFC_STAT_WR_DONE_BIT]));
			crc_done_reg   <= crc_finish
				| (crc_done_reg & ~(stat_wr & PWDATA_I[dfc_pkg::DFC_STAT_CRC_DONE_BIT]));
		end
	end

	// ***********************************************
	// program and erase
	// ***********************************************
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			write_busy_reg <= 1'b0;
		end else if (wr_ok) begin
			write_busy_reg <= 1'b1;
		end else if (ARR_DONE_I) begin
			write_busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			arr_start_reg <= 1'b0;
			arr_op_reg    <= 5'h00;
			arr_waddr_reg <= 15'h0000;
			arr_wdata_reg <= 32'h0000_0000;
		end else begin
			arr_start_reg <= wr_ok;
			if (wr_ok) begin
				arr_op_reg    <= mode;
				arr_waddr_reg <= MEM_ADDR_I;
				arr_wdata_reg <= MEM_WDATA_I;
			end
		end
	end

	// ***********************************************
	// read port shared by system reads and the crc engine
	// ***********************************************
	logic crc_step;
	logic rd_last;

	assign rd_last = (rd_cnt_reg == wait_reg);
	// background steps only when no write runs and no system access waits
	assign crc_step = crc_busy_reg & rd_idle & ~write_busy_reg & ~mem_ack_reg
		& (crc_burst_reg | ~MEM_REQ_I);

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			rd_state_reg <= dfc_pkg::DFC_RD_IDLE;
			rd_cnt_reg   <= 4'h0;
		end else begin
			case (rd_state_reg)
				dfc_pkg::DFC_RD_IDLE: begin
					rd_cnt_reg <= 4'h0;
					if (rd_req & ~f_otp) begin
						rd_state_reg <= dfc_pkg::DFC_RD_MEM;
					end else if (crc_step) begin
						rd_state_reg <= dfc_pkg::DFC_RD_CRC;
					end
				end
				dfc_pkg::DFC_RD_MEM, dfc_pkg::DFC_RD_CRC: begin
					if (rd_last) begin
						rd_state_reg <= dfc_pkg::DFC_RD_IDLE;
					end else begin
						rd_cnt_reg <= rd_cnt_reg + 4'h1;
					end
				end
				default: rd_state_reg <= dfc_pkg::DFC_RD_IDLE;
			endcase
		end
	end

	// a refused access is answered at once so the bus never hangs
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			mem_ack_reg   <= 1'b0;
			mem_rdata_reg <= 128'h0;
		end else begin
			mem_ack_reg <= wr_req | f_otp
				| ((rd_state_reg == dfc_pkg::DFC_RD_MEM) & rd_last);
			if ((rd_state_reg == dfc_pkg::DFC_RD_MEM) & rd_last) begin
				mem_rdata_reg <= ARR_RDATA_I;
			end
		end
	end

	// ***********************************************
	// crc engine
	// ***********************************************
	function automatic logic [15:0] crc_line(input logic [15:0] c, input logic [127:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 127; i >= 0; i--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? dfc_pkg::DFC_CRC_POLY : 16'h0000);
		end
		crc_line = r;
	endfunction

	logic crc_line_in;
	logic crc_start;
	logic crc_clear;

	assign crc_line_in = (rd_state_reg == dfc_pkg::DFC_RD_CRC) & rd_last;
	assign crc_next    = crc_line(crc_reg, ARR_RDATA_I);
	assign crc_finish  = crc_line_in & (crc_ptr_reg[14:4] >= crc_last_reg[14:4]);
	assign crc_clear   = wr_to(dfc_pkg::DFC_OFF_CRC_CTRL) & PWDATA_I[dfc_pkg::DFC_CRC_CLEAR_BIT];
	assign crc_start   = wr_to(dfc_pkg::DFC_OFF_CRC_CTRL) & ~crc_busy_reg
		& (PWDATA_I[dfc_pkg::DFC_CRC_BG_BIT] | PWDATA_I[dfc_pkg::DFC_CRC_BURST_BIT]);

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			crc_bg_reg    <= 1'b0;
			crc_burst_reg <= 1'b0;
			crc_irqen_reg <= 1'b0;
		end else if (wr_to(dfc_pkg::DFC_OFF_CRC_CTRL)) begin
			crc_bg_reg    <= PWDATA_I[dfc_pkg::DFC_CRC_BG_BIT];
			crc_burst_reg <= PWDATA_I[dfc_pkg::DFC_CRC_BURST_BIT];
			crc_irqen_reg <= PWDATA_I[dfc_pkg::DFC_CRC_IRQEN_BIT];
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			crc_first_reg <= 15'h0000;
			crc_last_reg  <= dfc_pkg::DFC_CRC_END_RESET;
		end else begin
			if (wr_to(dfc_pkg::DFC_OFF_CRC_START)) begin
				crc_first_reg <= {PWDATA_I[14:4], 4'h0};
			end
			if (wr_to(dfc_pkg::DFC_OFF_CRC_END)) begin
				crc_last_reg <= {PWDATA_I[14:4], 4'hf};
			end
		end
	end

	// disabling both modes mid-run aborts the run without done
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			crc_busy_reg <= 1'b0;
			crc_ptr_reg  <= 15'h0000;
		end else if (crc_start) begin
			crc_busy_reg <= 1'b1;
			crc_ptr_reg  <= crc_first_reg;
		end else if (crc_finish | (wr_to(dfc_pkg::DFC_OFF_CRC_CTRL)
				& ~PWDATA_I[dfc_pkg::DFC_CRC_BG_BIT] & ~PWDATA_I[dfc_pkg::DFC_CRC_BURST_BIT])) begin
			crc_busy_reg <= 1'b0;
		end else if (crc_line_in) begin
			crc_ptr_reg <= crc_ptr_reg + dfc_pkg::DFC_LINE_STEP;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			crc_reg <= dfc_pkg::DFC_CRC_INIT;
		end else if (crc_clear) begin
			crc_reg <= dfc_pkg::DFC_CRC_INIT;
		end else if (crc_line_in) begin
			crc_reg <= crc_next;
		end
	end

	// ***********************************************
	// read data and outputs
	// ***********************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (off)
			dfc_pkg::DFC_OFF_CONFIG:    rd_mux = {28'h0, wait_reg};
			dfc_pkg::DFC_OFF_PROT:      rd_mux = prot_reg;
			dfc_pkg::DFC_OFF_CTRL:      rd_mux = ctrl_reg;
			dfc_pkg::DFC_OFF_STAT: begin
				rd_mux[dfc_pkg::DFC_STAT_WR_BUSY_BIT] = write_busy_reg;
				rd_mux[dfc_pkg::DFC_STAT_CRC_BUSY_BIT] = crc_busy_reg;
				rd_mux[dfc_pkg::DFC_STAT_WR_DONE_BIT] = write_done_reg;
				rd_mux[dfc_pkg::DFC_STAT_CRC_DONE_BIT] = crc_done_reg;
				rd_mux[dfc_pkg::DFC_STAT_LOCK_BIT]  = lock_fault_reg;
				rd_mux[dfc_pkg::DFC_STAT_OTP_BIT]   = otp_fault_reg;
				rd_mux[dfc_pkg::DFC_STAT_GUARD_BIT] = guard_fault_reg;
				rd_mux[dfc_pkg::DFC_STAT_SEQ_BIT]   = seq_fault_reg;
			end
			dfc_pkg::DFC_OFF_CRC_CTRL: begin
				rd_mux[dfc_pkg::DFC_CRC_BG_BIT]    = crc_bg_reg;
				rd_mux[dfc_pkg::DFC_CRC_BURST_BIT] = crc_burst_reg;
				rd_mux[dfc_pkg::DFC_CRC_IRQEN_BIT] = crc_irqen_reg;
			end
			dfc_pkg::DFC_OFF_CRC_OUT:   rd_mux = {16'h0000, crc_reg};
			dfc_pkg::DFC_OFF_CRC_START: rd_mux = {17'h00000, crc_first_reg};
			dfc_pkg::DFC_OFF_CRC_END:   rd_mux = {17'h00000, crc_last_reg};
			default:                    rd_mux = 32'h0000_0000;
		endcase
	end

	// read data latched in setup so it comes from a flip-flop in access
	logic [31:0] prdata_reg;
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_phase) begin
			prdata_reg <= mapped ? rd_mux : 32'h0000_0000;
		end
	end

	logic hold_reg;
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			hold_reg <= 1'b0;
		end else begin
			hold_reg <= (crc_busy_reg | crc_start) & ~crc_finish
				& (crc_start ? PWDATA_I[dfc_pkg::DFC_CRC_BURST_BIT] : crc_burst_reg);
		end
	end

	assign PRDATA_O       = prdata_reg;
	assign MEM_ACK_O      = mem_ack_reg;
	assign MEM_RDATA_O    = mem_rdata_reg;
	assign ARR_RD_O       = ~rd_idle;
	assign ARR_ADDR_O     = (rd_state_reg == dfc_pkg::DFC_RD_CRC) ? crc_ptr_reg : MEM_ADDR_I;
	assign ARR_START_O    = arr_start_reg;
	assign ARR_OP_O       = arr_op_reg;
	assign ARR_WADDR_O    = arr_waddr_reg;
	assign ARR_WDATA_O    = arr_wdata_reg;
	assign CPU_HOLD_O     = hold_reg;
	assign CRC_DONE_REQ_O = crc_done_reg & crc_irqen_reg;
endmodule // dfc_top

// ### tb_top.sv
// self-checking testbench for the data flash controller
`timescale 1ns/1ps
module tb_top;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [31:0]  pa = 32'h0, pwd = 32'h0;
	logic         mreq = 1'b0, mwr = 1'b0, motp = 1'b0;
	logic [14:0]  ma = 15'h0;
	logic [31:0]  mwd = 32'h0;
	logic         prdy, pslv, mack, ard, ast, adn, hold, creq;
	logic [31:0]  prd, awd, rq;
	logic [127:0] mrd, ardd, mline;
	logic [14:0]  aad, awa;
	logic [4:0]   aop;
	logic         rerr, held = 1'b0;
	int           fails = 0, num_checks = 0, lat, nstart = 0, cyc = 0;
	always #50 clk = ~clk;
	dfc_top u_dfc_top (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PREADY_O(prdy), .PRDATA_O(prd),
		.PSLVERR_O(pslv), .MEM_REQ_I(mreq), .MEM_WRITE_I(mwr), .MEM_OTP_I(motp),
		.MEM_ADDR_I(ma), .MEM_WDATA_I(mwd), .MEM_ACK_O(mack), .MEM_RDATA_O(mrd),
		.ARR_RD_O(ard), .ARR_ADDR_O(aad), .ARR_RDATA_I(ardd), .ARR_START_O(ast),
		.ARR_OP_O(aop), .ARR_WADDR_O(awa), .ARR_WDATA_O(awd), .ARR_DONE_I(adn),
		.CPU_HOLD_O(hold), .CRC_DONE_REQ_O(creq));
	dfc_flash_model u_dfc_flash_model (.clk_i(clk), .rd_i(ard), .addr_i(aad), .rdata_o(ardd),
		.start_i(ast), .op_i(aop), .waddr_i(awa), .wdata_i(awd), .done_o(adn));
	always @(posedge clk) begin
		cyc++;
		nstart += (ast === 1'b1);
		if (hold === 1'b1)
			held <= 1'b1;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	// ***********************************************
	// bus tasks
	// ***********************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] off, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= 32'h4100_1000 | {20'h0, off};
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (prdy !== 1'b1);
		rq = prd;
		rerr = pslv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [11:0] off, input logic [31:0] e);
		apb(1'b0, off, 32'h0);
		chk(nm, e, rq);
	endtask
	task automatic mem(input logic w, input logic o, input logic [14:0] a, input logic [31:0] d);
		@(posedge clk);
		mreq <= 1'b1;
		mwr <= w;
		motp <= o;
		ma <= a;
		mwd <= d;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (mack !== 1'b1);
		mline = mrd;
		mreq <= 1'b0;
	endtask
	task automatic idle(input int b);
		do
			apb(1'b0, 12'h018, 32'h0);
		while (rq[b] !== 1'b0);
	endtask
	function automatic logic [15:0] crc_exp(input int n);
		logic [15:0]  c;
		logic [127:0] l;
		c = 16'hffff;
		for (int i = 0; i < n; i++) begin
			l = {4{32'ha5c3_0000 | i}};
			for (int b = 127; b >= 0; b--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ l[b]) ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction
	// ***********************************************
	// scenarios
	// ***********************************************
	task automatic t_regs;
		logic [11:0] o [9];
		logic [31:0] v [9];
		o = '{12'h000, 12'h004, 12'h00c, 12'h014, 12'h018, 12'h030, 12'h034, 12'h038,
			12'h03c};
		v = '{32'h0, 32'h0, 32'h0, 32'h8000_0000, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h7fff};
		for (int i = 0; i < 9; i++)
			rdc("reset value", o[i], v[i]);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rerr});
		apb(1'b1, 12'h034, 32'h1234);
		rdc("result ro", 12'h034, 32'hffff);
		$display("t_regs done");
	endtask
	task automatic t_unlock;
		// no mode set yet: sequence fault too
		mem(1'b1, 1'b0, 15'h0100, 32'hdead_beef);
		rdc("lock fault", 12'h018, 32'h110000);
		chk("no start", 32'h0, nstart);
		apb(1'b1, 12'h018, 32'h110000);
		rdc("lock clear", 12'h018, 32'h0);
		apb(1'b1, 12'h004, 32'h1234_5678);
		apb(1'b1, 12'h004, 32'h0123_4567);
		apb(1'b1, 12'h004, 32'h2345_6789);
		apb(1'b1, 12'h014, 32'h1);
		rdc("bad order", 12'h014, 32'h8000_0001);
		apb(1'b1, 12'h004, 32'h0123_4567);
		apb(1'b1, 12'h004, 32'h1234_5678);
		apb(1'b1, 12'h004, 32'h2345_6789);
		apb(1'b1, 12'h014, 32'h1);
		rdc("unlocked", 12'h014, 32'h1);
		mem(1'b1, 1'b0, 15'h0100, 32'h1111_2222);
		mem(1'b1, 1'b0, 15'h0104, 32'h3333_4444);
		rdc("seq fault", 12'h018, 32'h100001);
		idle(0);
		rdc("write done", 12'h018, 32'h100100);
		apb(1'b1, 12'h018, 32'h100100);
		rdc("w1c", 12'h018, 32'h0);
		mem(1'b0, 1'b0, 15'h0100, 32'h0);
		chk("programmed", 32'h1111_2222, mline[31:0]);
		chk("faulted kept", 32'ha5c3_0010, mline[63:32]);
		$display("t_unlock done");
	endtask
	task automatic t_guard;
		apb(1'b1, 12'h00c, 32'h1004000);
		rdc("guard reg", 12'h00c, 32'h1004000);
		mem(1'b1, 1'b0, 15'h7200, 32'h5);
		rdc("guard fault", 12'h018, 32'h40000);
		apb(1'b1, 12'h018, 32'h40000);
		mem(1'b1, 1'b0, 15'h7000, 32'h5);
		idle(0);
		rdc("released", 12'h018, 32'h100);
		apb(1'b1, 12'h018, 32'h100);
		apb(1'b1, 12'h014, 32'h4000_0001);
		mem(1'b1, 1'b1, 15'h0000, 32'h5);
		rdc("otp fault", 12'h018, 32'h20000);
		apb(1'b1, 12'h018, 32'h20000);
		rdc("otp clear", 12'h018, 32'h0);
		$display("t_guard done");
	endtask
	task automatic t_wait;
		int w [5] = '{0, 1, 4, 7, 15};
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h000, w[i]);
			rdc("wait field", 12'h000, w[i]);
			mem(1'b0, 1'b0, 15'h0230, 32'h0);
			chk("read cycles", w[i] + 3, lat);
			chk("read data", 32'ha5c3_0023, mline[95:64]);
		end
		$display("t_wait done");
	endtask
	task automatic t_crc;
		apb(1'b1, 12'h038, 32'h0);
		apb(1'b1, 12'h03c, 32'h1f);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, 12'h030, 32'h10000);
			rdc("crc clear", 12'h034, 32'hffff);
			apb(1'b1, 12'h030, m ? 32'h2 : 32'h101);
			idle(1);
			rdc("crc", 12'h034, {16'h0, crc_exp(2)});
			rdc("crc done", 12'h018, 32'h200);
			chk("done req", {31'h0, m == 0}, {31'h0, creq});
			apb(1'b1, 12'h018, 32'h200);
		end
		chk("cpu held", 32'h1, {31'h0, held});
		$display("t_crc done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_unlock();
		t_guard();
		t_wait();
		t_crc();
		end_of_test();
	end
endmodule // tb_top
